// [port_inc_pkg.sv]
`default_nettype none
package port_inc_pkg;

  // apb register offsets (byte addresses)
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC_FLAGS = 8'h04;
  localparam logic [7:0] OFS_COUNT_PORT = 8'h08;
  localparam logic [7:0] OFS_GENERAL_TWO = 8'h0C;
  localparam logic [7:0] OFS_MEM_POINTER = 8'h10;
  localparam logic [7:0] OFS_STACK_TOP = 8'h14;
  localparam logic [7:0] OFS_FIRST_OFFSET = 8'h18;
  localparam logic [7:0] OFS_SECOND_OFFSET = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // flag register bit positions
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_HALF = 4;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_SUB = 1;
  localparam int FLAG_CARRY = 0;

  // status register bit positions
  localparam int STAT_UNSUPPORTED = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_IO_ACTIVE = 2;
  localparam int STAT_IO_BYTE_LSB = 8;

  // opcode bytes
  localparam logic [7:0] OPC_IN_IMM = 8'hDB;
  localparam logic [7:0] OPC_EXT_PREFIX = 8'hED;
  localparam logic [7:0] OPC_FIRST_IDX = 8'hDD;
  localparam logic [7:0] OPC_SECOND_IDX = 8'hFD;
  localparam logic [7:0] OPC_IDX_INC = 8'h23;

  // destination field codes
  localparam logic [2:0] DST_FLAGS_ONLY = 3'h6;
  localparam logic [2:0] DST_ACC = 3'h7;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] PAIR_RESET = 16'h0000;

  // i/o read strobe length in ref_clk cycles
  localparam int IO_READ_CYCLES = 3;

  // decoder states
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_PORT_NUM,
    ST_EXT,
    ST_INDEX,
    ST_IO_WAIT
  } exec_state_t;

  // architectural registers
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] h;
    logic [7:0] l;
    logic [15:0] stack_top_pointer;
    logic [15:0] first_offset_pointer;
    logic [15:0] second_offset_pointer;
  } core_regs_t;

  // one i/o read request
  typedef struct packed {
    logic start;
    logic [15:0] addr;
  } io_req_t;

  // answer of the i/o read unit
  typedef struct packed {
    logic done;
    logic active;
    logic [7:0] data;
  } io_rsp_t;

endpackage : port_inc_pkg
`default_nettype wire

// [io_read_unit.sv]
`default_nettype none
// one i/o read bus cycle: address and strobe held, data sampled at the end
module io_read_unit
  import port_inc_pkg::*;
#(
  parameter int READ_CYCLES = IO_READ_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire io_req_t req,
  input wire logic [7:0] io_rdata,
  output var io_rsp_t rsp,
  output logic [15:0] io_addr,
  output logic io_rd
);

  localparam int CNT_W = $clog2(READ_CYCLES + 1);

  // whole state of the unit
  typedef struct packed {
    logic [7:0] sync1;   // first stage, read only by sync2
    logic [7:0] sync2;
    logic [CNT_W-1:0] cnt;
    logic rd;
    logic [15:0] addr;
    logic done;
    logic [7:0] data;
  } io_state_t;

  io_state_t s_r;
  io_state_t s_nxt;

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = io_rdata;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.done = 1'b0;
    if (s_r.rd) begin
      // last strobe cycle: data had two edges to pass the synchroniser
      if (s_r.cnt == CNT_W'(1)) begin
        s_nxt.rd = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.data = s_r.sync2;
      end else begin
        s_nxt.cnt = s_r.cnt - CNT_W'(1);
      end
    end else if (req.start) begin
      // start only when idle, so the address never moves mid-cycle
      s_nxt.rd = 1'b1;
      s_nxt.addr = req.addr;
      s_nxt.cnt = CNT_W'(READ_CYCLES);
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign io_addr = s_r.addr;
  assign io_rd = s_r.rd;
  assign rsp.done = s_r.done;
  assign rsp.active = s_r.rd;
  assign rsp.data = s_r.data;

endmodule : io_read_unit
`default_nettype wire

// [port_input_and_pair_increment_exec.sv]
// Notes on behaviour
// - immediate port number on low address byte
// - accumulator on high address byte
// - immediate input loads accumulator, flags kept
// - count pair drives whole address
// - indirect input loads field-selected register
// - prefix plus byte with 3-bit destination
// - sign flag copies input bit 7
// - zero flag set for all-zero byte
// - parity even sets flag; clear half, subtract
// - pair increment adds one, flags kept
// - two-bit field picks one of four pairs
// - first index prefix increments first pointer
// - second index prefix increments second pointer
`default_nettype none
module port_input_and_pair_increment_exec
  import port_inc_pkg::*;
#(
  parameter int READ_CYCLES = IO_READ_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] io_addr,
  output logic io_rd,
  input wire logic [7:0] io_rdata
);

  // whole state of the executer
  // everything remembered between clock edges, except the state inside u_io, lives here
  typedef struct packed {
    exec_state_t st;
    core_regs_t regs;
    logic [2:0] dest;        // destination of pending indirect input
    logic pend_imm;          // pending input goes to accumulator
    logic pend_second;       // index prefix seen was the second one
    logic unsupported;       // sticky, byte not in this block's set
    io_req_t io_req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } exec_state_s_t;

  exec_state_s_t s_r;
  exec_state_s_t s_nxt;
  io_rsp_t io_rsp;

  // wraps from all ones to zero, no carry out
  // carry dropped on purpose: these increments touch no flag
  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = v + 16'h0001;
  endfunction : inc16

  // write one byte register by destination code
  function automatic core_regs_t put_r8(input core_regs_t r, input logic [2:0] sel,
                                        input logic [7:0] v);
    put_r8 = r;
    case (sel)
      3'h0: put_r8.b = v;
      3'h1: put_r8.c = v;
      3'h2: put_r8.d = v;
      3'h3: put_r8.e = v;
      3'h4: put_r8.h = v;
      3'h5: put_r8.l = v;
      // code 111 is the accumulator; 110 has no register
      DST_ACC: put_r8.acc = v;
      default: put_r8 = r;  // code 110 touches flags only
    endcase
  endfunction : put_r8

  // i/o bus cycle unit
  // one read at a time; the decoder sits in io wait until done
  io_read_unit #(
    .READ_CYCLES(READ_CYCLES)
  ) u_io (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .req(s_r.io_req),
    .io_rdata(io_rdata),
    .rsp(io_rsp),
    .io_addr(io_addr),
    .io_rd(io_rd)
  );

  // bus qualifiers shared by register and decode logic
  logic apb_take;     // write or read completes this edge
  logic instr_write;  // opcode byte accepted
  logic [7:0] ib;     // incoming instruction byte

  assign apb_take = psel && penable && s_r.pready;
  assign instr_write = apb_take && pwrite && (paddr == OFS_INSTR);
  assign ib = pwdata[7:0];

  // decode, execute and register bus
  always_comb begin
    s_nxt = s_r;
    s_nxt.io_req.start = 1'b0;

    // apb: one wait cycle, then pready for exactly one cycle
    // the wait cycle gives the read mux a whole clock to settle
    s_nxt.pready = psel && penable && !s_r.pready;
    if (psel && penable && !s_r.pready) begin
      s_nxt.pslverr = 1'b0;
      case (paddr)
        // state code shows a half-fed instruction
        OFS_INSTR: s_nxt.prdata = {29'h0, s_r.st};
        // accumulator low byte, flags above it
        OFS_ACC_FLAGS: s_nxt.prdata = {16'h0, s_r.regs.flags, s_r.regs.acc};
        // pairs read high register in the upper byte
        OFS_COUNT_PORT: s_nxt.prdata = {16'h0, s_r.regs.b, s_r.regs.c};
        OFS_GENERAL_TWO: s_nxt.prdata = {16'h0, s_r.regs.d, s_r.regs.e};
        OFS_MEM_POINTER: s_nxt.prdata = {16'h0, s_r.regs.h, s_r.regs.l};
        OFS_STACK_TOP: s_nxt.prdata = {16'h0, s_r.regs.stack_top_pointer};
        OFS_FIRST_OFFSET: s_nxt.prdata = {16'h0, s_r.regs.first_offset_pointer};
        OFS_SECOND_OFFSET: s_nxt.prdata = {16'h0, s_r.regs.second_offset_pointer};
        // sticky error, busy, strobe and last byte
        OFS_STATUS: begin
          s_nxt.prdata = 32'h0;
          s_nxt.prdata[STAT_UNSUPPORTED] = s_r.unsupported;
          s_nxt.prdata[STAT_BUSY] = (s_r.st != ST_FETCH);
          s_nxt.prdata[STAT_IO_ACTIVE] = io_rsp.active;
          s_nxt.prdata[STAT_IO_BYTE_LSB +: 8] = io_rsp.data;
        end
        default: begin
          // unmapped: error answer, zero data
          s_nxt.prdata = 32'h0;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // register writes other than the status clear are refused while an i/o read is in flight
    // otherwise software could move the count pair under a read
    if (apb_take && pwrite && (s_r.st != ST_IO_WAIT)) begin
      case (paddr)
        // preload between instructions, flags in bits 15:8
        OFS_ACC_FLAGS: begin
          s_nxt.regs.acc = pwdata[7:0];
          s_nxt.regs.flags = pwdata[15:8];
        end
        OFS_COUNT_PORT: {s_nxt.regs.b, s_nxt.regs.c} = pwdata[15:0];
        OFS_GENERAL_TWO: {s_nxt.regs.d, s_nxt.regs.e} = pwdata[15:0];
        OFS_MEM_POINTER: {s_nxt.regs.h, s_nxt.regs.l} = pwdata[15:0];
        // pointers take the low half word, upper half ignored
        OFS_STACK_TOP: s_nxt.regs.stack_top_pointer = pwdata[15:0];
        OFS_FIRST_OFFSET: s_nxt.regs.first_offset_pointer = pwdata[15:0];
        OFS_SECOND_OFFSET: s_nxt.regs.second_offset_pointer = pwdata[15:0];
        default: begin
        end
      endcase
    end

    // status write of 1 clears the sticky unsupported bit
    // cleared first, so a same-cycle set in the decoder wins
    if (apb_take && pwrite && (paddr == OFS_STATUS) && pwdata[STAT_UNSUPPORTED]) begin
      s_nxt.unsupported = 1'b0;
    end

    // decoder
    // one instruction byte arrives per write to the instruction register
    case (s_r.st)
      // first byte of every instruction
      // a second byte is only looked at in the port number and prefix states
      ST_FETCH: begin
        if (instr_write) begin
          if (ib == OPC_IN_IMM) begin
            s_nxt.st = ST_PORT_NUM;
          end else if (ib == OPC_EXT_PREFIX) begin
            s_nxt.st = ST_EXT;
          end else if (ib == OPC_FIRST_IDX || ib == OPC_SECOND_IDX) begin
            s_nxt.st = ST_INDEX;
            s_nxt.pend_second = (ib == OPC_SECOND_IDX);
          end else if (ib[7:6] == 2'b00 && ib[3:0] == 4'h3) begin
            case (ib[5:4])
              2'b00: {s_nxt.regs.b, s_nxt.regs.c} = inc16({s_r.regs.b, s_r.regs.c});
              2'b01: {s_nxt.regs.d, s_nxt.regs.e} = inc16({s_r.regs.d, s_r.regs.e});
              2'b10: {s_nxt.regs.h, s_nxt.regs.l} = inc16({s_r.regs.h, s_r.regs.l});
              default: s_nxt.regs.stack_top_pointer = inc16(s_r.regs.stack_top_pointer);
            endcase
          end else begin
            s_nxt.unsupported = 1'b1;
          end
        end
      end
      // immediate input waits for its port byte
      ST_PORT_NUM: begin
        if (instr_write) begin
          s_nxt.io_req.addr = {s_r.regs.acc, ib};
          s_nxt.io_req.start = 1'b1;
          s_nxt.pend_imm = 1'b1;
          s_nxt.st = ST_IO_WAIT;
        end
      end
      // extended prefix seen, second byte picks the input
      ST_EXT: begin
        if (instr_write) begin
          if (ib[7:6] == 2'b01 && ib[2:0] == 3'h0) begin
            // low register low byte, high register high byte
            s_nxt.io_req.addr = {s_r.regs.b, s_r.regs.c};
            s_nxt.io_req.start = 1'b1;
            s_nxt.pend_imm = 1'b0;
            s_nxt.dest = ib[5:3];
            s_nxt.st = ST_IO_WAIT;
          end else begin
            s_nxt.unsupported = 1'b1;
            s_nxt.st = ST_FETCH;
          end
        end
      end
      // index prefix seen, only the increment may follow
      ST_INDEX: begin
        if (instr_write) begin
          s_nxt.st = ST_FETCH;
          if (ib == OPC_IDX_INC) begin
            if (s_r.pend_second) begin
              s_nxt.regs.second_offset_pointer = inc16(s_r.regs.second_offset_pointer);
            end else begin
              s_nxt.regs.first_offset_pointer = inc16(s_r.regs.first_offset_pointer);
            end
          end else begin
            s_nxt.unsupported = 1'b1;
          end
        end
      end
      // bus cycle in flight, decoder holds until the answer
      ST_IO_WAIT: begin
        // opcode writes here are ignored; status shows busy
        if (io_rsp.done) begin
          s_nxt.st = ST_FETCH;
          // pending flag picks which of the two inputs finishes
          if (s_r.pend_imm) begin
            s_nxt.regs.acc = io_rsp.data;
          end else begin
            s_nxt.regs = put_r8(s_r.regs, s_r.dest, io_rsp.data);
            s_nxt.regs.flags[FLAG_SIGN] = io_rsp.data[7];
            s_nxt.regs.flags[FLAG_ZERO] = (io_rsp.data == 8'h00);
            // even parity, half and subtract cleared
            s_nxt.regs.flags[FLAG_PARITY] = ~^io_rsp.data;
            s_nxt.regs.flags[FLAG_HALF] = 1'b0;
            s_nxt.regs.flags[FLAG_SUB] = 1'b0;
          end
        end
      end
      // unused state codes recover to fetch
      default: s_nxt.st = ST_FETCH;
    endcase

    // a new unsupported byte in the clearing cycle keeps the bit set
    if (s_r.st != ST_IO_WAIT && instr_write && s_nxt.st == s_r.st && s_r.st != ST_FETCH) begin
      s_nxt.unsupported = s_nxt.unsupported;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_r.st <= ST_FETCH;
      // every architectural register starts at zero
      s_r.regs <= '{acc: BYTE_RESET, flags: BYTE_RESET, b: BYTE_RESET, c: BYTE_RESET,
                    d: BYTE_RESET, e: BYTE_RESET, h: BYTE_RESET, l: BYTE_RESET,
                    stack_top_pointer: PAIR_RESET, first_offset_pointer: PAIR_RESET,
                    second_offset_pointer: PAIR_RESET};
      s_r.dest <= 3'h0;
      s_r.pend_imm <= 1'b0;
      s_r.pend_second <= 1'b0;
      s_r.unsupported <= 1'b0;
      s_r.io_req <= '0;
      s_r.prdata <= 32'h0;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // top outputs come straight from the state flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

endmodule : port_input_and_pair_increment_exec
`default_nettype wire

// [port_exec_props.sv]
`default_nettype none
module port_exec_props
  import port_inc_pkg::*;
#(
  parameter int READ_CYCLES = IO_READ_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // instruction byte taken by the slave
  logic ins_wr;
  // armed by the immediate opcode
  logic imm_r;
  // last instruction byte taken
  logic [7:0] pw_r;
  // strobe cycles so far
  int run_r;
  assign ins_wr = psel && penable && pready && pwrite && paddr == OFS_INSTR;
  // shadow of the two-byte sequencing, good only while no byte is refused
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      imm_r <= 1'b0;
      pw_r <= 8'h00;
      run_r <= 0;
    end else begin
      if (ins_wr) begin
        imm_r <= pwdata[7:0] == OPC_IN_IMM && !imm_r;
        pw_r <= pwdata[7:0];
      end
      run_r <= io_rd ? run_r + 1 : 0;
    end
  end
  // access phase with one wait
  sequence one_wait;
    !pready ##1 pready;
  endsequence
  // strobe starts with the port byte low
  sequence port_strobe;
    $rose(io_rd) && io_addr[7:0] == pw_r;
  endsequence
  chk_rd_long: assert property (io_rd |-> run_r < READ_CYCLES)
    else $error("read strobe too long");
  chk_rd_short: assert property ($fell(io_rd) && $past(resetn) |-> run_r == READ_CYCLES)
    else $error("read strobe too short");
  chk_addr_hold: assert property (io_rd && $past(io_rd) |-> $stable(io_addr))
    else $error("io address moved in strobe");
  chk_port_low: assert property (ins_wr && imm_r |-> ##[1:2] port_strobe)
    else $error("port byte not on low address");
  chk_rd_cause: assert property ($rose(io_rd) |-> $past(ins_wr) || $past(ins_wr, 2))
    else $error("strobe without instruction byte");
  chk_apb_wait: assert property (psel && $rose(penable) |-> one_wait)
    else $error("access phase length wrong");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  chk_err_map: assert property (pready && paddr > OFS_STATUS |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule : port_exec_props

bind port_input_and_pair_increment_exec port_exec_props #(.READ_CYCLES(READ_CYCLES)) chk_i (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata));
`default_nettype wire

// [io_port_model.sv]
`default_nettype none
module io_port_model #(
  parameter int LAG = 0
) (
  input wire logic ref_clk,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  output logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles of the current strobe
  int n_r = 0;
  // floating bus pattern, flips each cycle so no stale byte passes
  logic [7:0] idle_r = 8'hA5;
  // strobe length and idle pattern
  always_ff @(posedge ref_clk) begin
    n_r <= io_rd ? n_r + 1 : 0;
    idle_r <= ~idle_r;
  end
  assign io_rdata = io_rd && n_r >= LAG ? io_addr[7:0] ^ 8'h3C : idle_r;
endmodule : io_port_model
`default_nettype wire

// [port_input_and_pair_increment_exec_tb.sv]
`default_nettype none
module port_input_and_pair_increment_exec_tb
  import port_inc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] io_addr;
  logic io_rd;
  logic [7:0] io_rdata;
  // address of the last strobe
  logic [15:0] seen_addr;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  // port bytes: zero, sign, parity cases
  logic [7:0] dv [8] = '{8'h00, 8'h80, 8'h03, 8'h7F, 8'hFF, 8'h01, 8'h55, 8'h96};
  port_input_and_pair_increment_exec uut (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata));
  io_port_model peer (.ref_clk(ref_clk), .io_rd(io_rd), .io_addr(io_addr), .io_rdata(io_rdata));
  // 125 MHz clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // strobe address capture and hang limit
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (io_rd === 1'b1) seen_addr <= io_addr;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, held until ready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("register %h", a), x & m, q & m);
    chk("slave error", {31'h0, a > OFS_STATUS}, {31'h0, e});
  endtask : rd
  // feed one instruction byte, then wait out any i/o read it started;
  // busy stays up between prefix and second byte, so the state is polled
  task automatic issue(input logic [7:0] b);
    logic [31:0] q;
    logic e;
    apb(1'b1, OFS_INSTR, {24'h0, b}, q, e);
    q = {29'h0, ST_IO_WAIT};
    while (q[2:0] === ST_IO_WAIT) apb(1'b0, OFS_INSTR, 32'h0, q, e);
  endtask : issue
  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] f;
    logic [15:0] v;
    logic [31:0] m;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // reset values, last place unmapped
    for (int i = 1; i <= 9; i++) rd(8'(i * 4), 32'h0, 32'hFFFF);
    wr(OFS_ACC_FLAGS, 32'hD75A);
    issue(OPC_IN_IMM);
    issue(8'h41);
    chk("port address", 32'h5A41, {16'h0, seen_addr});
    rd(OFS_ACC_FLAGS, 32'hD77D, 32'hFFFF);
    // a byte outside the set raises the sticky bit, a one clears it
    issue(8'h00);
    rd(OFS_STATUS, 32'h1, 32'h3);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0, 32'h3);
    // every destination code
    for (int r = 0; r < 8; r++) begin
      d = dv[r];
      c = d ^ 8'h3C;
      v = {8'(r * 17), c};
      wr(OFS_ACC_FLAGS, 32'hFF00);
      wr(OFS_COUNT_PORT, {16'h0, v});
      issue(OPC_EXT_PREFIX);
      rd(OFS_STATUS, 32'h2, 32'h3);
      issue({2'h1, 3'(r), 3'h0});
      rd(OFS_STATUS, {16'h0, d, 8'h00}, 32'hFF07);
      chk("pair address", {16'h0, v}, {16'h0, seen_addr});
      f = {d[7], d == 8'h00, 3'h0, ~^d, 2'h1};
      rd(OFS_ACC_FLAGS, {16'h0, f, r == 7 ? d : 8'h00}, 32'hD7FF);
      m = r[0] ? 32'h00FF : 32'hFF00;
      if (r < 6) rd(8'(OFS_COUNT_PORT + r / 2 * 4), {16'h0, d, d}, m);
    end
    // four pairs then both index pointers, wrap and carry across bytes
    wr(OFS_ACC_FLAGS, 32'h5500);
    for (int p = 0; p < 6; p++) begin
      v = p[0] ? 16'h12FF : 16'hFFFF;
      wr(8'(OFS_COUNT_PORT + p * 4), {16'h0, v});
      if (p < 4) begin
        issue({2'h0, 2'(p), 4'h3});
      end else begin
        issue(p == 4 ? OPC_FIRST_IDX : OPC_SECOND_IDX);
        issue(OPC_IDX_INC);
      end
      rd(8'(OFS_COUNT_PORT + p * 4), {16'h0, v + 16'h1}, 32'hFFFF);
    end
    rd(OFS_ACC_FLAGS, 32'h5500, 32'hFF00);
    wrap_up();
  end
endmodule : port_input_and_pair_increment_exec_tb
`default_nettype wire
